// ===== ptf_map.vh
`ifndef PTF_MAP_VH
`define PTF_MAP_VH

// Register byte offsets
`define PTF_OFF_GEN_CTRL1 12'h000
`define PTF_OFF_GEN_CTRL2 12'h004
`define PTF_OFF_GEN_DST_LO 12'h008
`define PTF_OFF_GEN_SRC_LO 12'h00C
`define PTF_OFF_GEN_ADDR_HI 12'h010
`define PTF_OFF_GOOD_CNT 12'h014
`define PTF_OFF_BAD_CNT 12'h018
`define PTF_OFF_LOOP_CTRL 12'h01C
`define PTF_OFF_IRQ_STATUS 12'h020
`define PTF_OFF_IRQ_CLEAR 12'h024
`define PTF_OFF_IRQ_ENABLE 12'h028

// Generator control 1 fields
`define PTF_C1_ENABLE 0
`define PTF_C1_RUN 1
`define PTF_C1_DURATION 2
`define PTF_C1_BAD_FCS 3
`define PTF_C1_PATTERN_LSB 4
`define PTF_C1_PATTERN_MSB 11

// Generator control 2 fields
`define PTF_C2_SIZE_LSB 0
`define PTF_C2_SIZE_MSB 10
`define PTF_C2_GAP_LSB 16
`define PTF_C2_GAP_MSB 23

// Loopback control fields
`define PTF_LB_FAR 0
`define PTF_LB_NEAR 1
`define PTF_LB_CABLE 2
`define PTF_LB_NO_XOVER 3

// Good counter register fields
`define PTF_GC_ACTIVE 16

// Interrupt status bits
`define PTF_IRQ_GEN_DONE 0
`define PTF_IRQ_RX_GOOD 1
`define PTF_IRQ_RX_BAD 2
`define PTF_IRQ_WIDTH 3

// Reset values
`define PTF_RST_CTRL2 32'h000C_0040
`define PTF_RST_CTRL1 32'h0000_0000

// Counts
`define PTF_GOOD_MAX 14'h270F
`define PTF_BAD_MAX 8'hFF
`define PTF_FRAME_LIMIT 30000000
`define PTF_MIN_SIZE 11'h040

`endif

// ===== ptf_frame_gen.v
`timescale 1ns/1ps
`include "ptf_map.vh"

module ptf_frame_gen #(
    parameter FRAME_LIMIT = `PTF_FRAME_LIMIT
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Settings
    input wire run,
    input wire duration,
    input wire bad_fcs,
    input wire [7:0] pattern,
    input wire [10:0] size,
    input wire [7:0] gap,
    input wire [47:0] dst_addr,
    input wire [47:0] src_addr,
    input wire tx_step,
    // Byte stream
    output reg gen_valid,
    output reg [7:0] gen_data,
    output reg gen_err,
    output reg frame_done,
    output reg limit_hit
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SEND = 3'b010;
    localparam ST_GAP = 3'b100;

    reg [2:0] state;
    reg [10:0] idx;
    reg [7:0] gap_cnt;
    reg [24:0] frames;
    wire [10:0] len;

    assign len = (size < `PTF_MIN_SIZE) ? `PTF_MIN_SIZE : size;

    // Header bytes then pattern payload
    function [7:0] frame_byte;
        input [10:0] i;
        input [47:0] d;
        input [47:0] s;
        input [7:0] p;
        begin
            if (i < 11'd6) begin
                frame_byte = d[8'd47 - {i[4:0], 3'b000} -: 8];
            end else if (i < 11'd12) begin
                frame_byte = s[8'd95 - {i[4:0], 3'b000} -: 8];
            end else begin
                frame_byte = p;
            end
        end
    endfunction

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            idx <= 11'h000;
            gap_cnt <= 8'h00;
            frames <= 25'h0000000;
            gen_valid <= 1'b0;
            gen_data <= 8'h00;
            gen_err <= 1'b0;
            frame_done <= 1'b0;
            limit_hit <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            limit_hit <= 1'b0;
            case (state)
                ST_IDLE: begin
                    gen_valid <= 1'b0;
                    frames <= 25'h0000000;
                    idx <= 11'h000;
                    if (run && !limit_hit) begin
                        state <= ST_SEND; // [R3]
                    end
                end
                ST_SEND: begin
                    if (!run && idx == 11'h000) begin
                        state <= ST_IDLE;
                    end else if (tx_step) begin // [R6]
                        gen_valid <= 1'b1;
                        gen_data <= frame_byte(idx, dst_addr, src_addr, pattern); // [R4]
                        gen_err <= bad_fcs && (idx == len - 11'd1);
                        if (idx == len - 11'd1) begin
                            idx <= 11'h000;
                            gap_cnt <= gap;
                            frame_done <= 1'b1;
                            state <= ST_GAP;
                            if (!duration && frames == FRAME_LIMIT - 1) begin
                                limit_hit <= 1'b1; // [R5]
                                state <= ST_IDLE;
                            end else begin
                                frames <= frames + 25'd1;
                            end
                        end else begin
                            idx <= idx + 11'd1;
                        end
                    end
                end
                ST_GAP: begin
                    if (tx_step) begin
                        gen_valid <= 1'b0;
                        gen_err <= 1'b0;
                        if (gap_cnt == 8'h00) begin
                            state <= run ? ST_SEND : ST_IDLE;
                        end else begin
                            gap_cnt <= gap_cnt - 8'd1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== ptf_test_top.v
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "ptf_map.vh"

// How it works
// [R1] Generator enable makes the generator the sole media transmit source, except in digital loopback, where nothing goes out.
// [R2] While generating, MAC transmit frames are dropped; receive path stays live.
// [R3] Writing run starts generated frames with the current settings.
// [R4] Addresses, size, gap, FCS, duration and pattern are configurable.
// [R5] With duration zero, run clears itself after thirty million frames.
// [R6] Generator works at 10, 100 and 1000 megabit line speeds.
// [R7] Good counter counts to 9999, then wraps to zero and continues.
// [R8] CRC-error counter saturates at 255.
// [R9] Any received frame sets the active flag; reading it clears it.
// [R10] Each received frame increments exactly one of the two counters.
// [R11] Reading a counter clears it to zero.
// [R12] Far-end loopback sends received media data back to the partner.
// [R13] Far-end loopback still feeds MAC receive; MAC transmit is ignored.
// [R14] Digital loopback returns MAC transmit to MAC receive; nothing goes out.
// [R15] Connector loopback works at all speeds using normal mode settings.
// [R16] Software sets cable loopback first, then disables crossover correction.
// [R17] A frame ending during a counter read is kept as the new count.
module ptf_test_top #(
    parameter FRAME_LIMIT = `PTF_FRAME_LIMIT
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Line speed: 00 ten, 01 hundred, 10 thousand
    input wire [1:0] speed,
    // MAC transmit side
    input wire mac_tx_en,
    input wire [7:0] mac_txd,
    input wire mac_tx_er,
    // MAC receive side
    output reg mac_rx_dv,
    output reg [7:0] mac_rxd,
    output reg mac_rx_er,
    // Media transmit side
    output reg med_tx_en,
    output reg [7:0] med_txd,
    output reg med_tx_er,
    // Media receive side
    input wire med_rx_dv,
    input wire [7:0] med_rxd,
    input wire med_rx_er,
    input wire med_rx_end,
    input wire med_rx_crc_ok,
    // Connector loopback controls
    output wire cable_loop_en,
    output wire xover_fix_off,
    // Interrupt
    output wire irq
);
    reg [31:0] ctrl1;
    reg [31:0] ctrl2;
    reg [31:0] dst_lo;
    reg [31:0] src_lo;
    reg [31:0] addr_hi;
    reg [3:0] loop_ctrl;
    reg [13:0] good_cnt;
    reg [7:0] bad_cnt;
    reg cnt_active;
    reg [`PTF_IRQ_WIDTH-1:0] irq_status;
    reg [`PTF_IRQ_WIDTH-1:0] irq_enable;
    reg [6:0] step_div;
    reg tx_step;
    wire gen_valid;
    wire [7:0] gen_data;
    wire gen_err;
    wire frame_done;
    wire limit_hit;
    wire gen_on;
    wire far_on;
    wire near_on;
    wire access;
    wire wr;
    wire rd;
    wire rx_good;
    wire rx_bad;
    wire rd_good;
    wire rd_bad;
    wire [`PTF_IRQ_WIDTH-1:0] irq_events;

    // Single-cycle slave; every address answers OKAY
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign rd_good = rd && paddr == `PTF_OFF_GOOD_CNT;
    assign rd_bad = rd && paddr == `PTF_OFF_BAD_CNT;

    assign gen_on = ctrl1[`PTF_C1_ENABLE];
    assign far_on = loop_ctrl[`PTF_LB_FAR];
    assign near_on = loop_ctrl[`PTF_LB_NEAR];
    assign cable_loop_en = loop_ctrl[`PTF_LB_CABLE]; // [R15]
    assign xover_fix_off = loop_ctrl[`PTF_LB_NO_XOVER]; // [R16]

    assign rx_good = med_rx_end && med_rx_crc_ok;
    assign rx_bad = med_rx_end && !med_rx_crc_ok;
    assign irq_events = {rx_bad, rx_good, limit_hit};
    assign irq = |(irq_status & irq_enable);

    // Byte pacing per line speed
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            step_div <= 7'h00;
            tx_step <= 1'b0;
        end else begin
            if (speed[1] || step_div == 7'h00) begin
                step_div <= (speed == 2'b00) ? 7'h63 : 7'h09; // [R6]
                tx_step <= 1'b1;
            end else begin
                step_div <= step_div - 7'd1;
                tx_step <= 1'b0;
            end
        end
    end

    ptf_frame_gen #(
        .FRAME_LIMIT(FRAME_LIMIT)
    ) u_gen (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(gen_on && ctrl1[`PTF_C1_RUN]),
        .duration(ctrl1[`PTF_C1_DURATION]),
        .bad_fcs(ctrl1[`PTF_C1_BAD_FCS]),
        .pattern(ctrl1[`PTF_C1_PATTERN_MSB:`PTF_C1_PATTERN_LSB]),
        .size(ctrl2[`PTF_C2_SIZE_MSB:`PTF_C2_SIZE_LSB]),
        .gap(ctrl2[`PTF_C2_GAP_MSB:`PTF_C2_GAP_LSB]),
        .dst_addr({addr_hi[15:0], dst_lo}),
        .src_addr({addr_hi[31:16], src_lo}),
        .tx_step(tx_step),
        .gen_valid(gen_valid),
        .gen_data(gen_data),
        .gen_err(gen_err),
        .frame_done(frame_done),
        .limit_hit(limit_hit)
    );

    // Register writes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl1 <= `PTF_RST_CTRL1;
            ctrl2 <= `PTF_RST_CTRL2;
            dst_lo <= 32'h0000_0000;
            src_lo <= 32'h0000_0000;
            addr_hi <= 32'h0000_0000;
            loop_ctrl <= 4'h0;
            irq_enable <= {`PTF_IRQ_WIDTH{1'b0}};
        end else begin
            if (wr && paddr == `PTF_OFF_GEN_CTRL1) begin
                ctrl1 <= pwdata;
            end else if (wr && paddr == `PTF_OFF_GEN_CTRL2) begin
                ctrl2 <= pwdata;
            end else if (wr && paddr == `PTF_OFF_GEN_DST_LO) begin
                dst_lo <= pwdata;
            end else if (wr && paddr == `PTF_OFF_GEN_SRC_LO) begin
                src_lo <= pwdata;
            end else if (wr && paddr == `PTF_OFF_GEN_ADDR_HI) begin
                addr_hi <= pwdata;
            end else if (wr && paddr == `PTF_OFF_LOOP_CTRL) begin
                loop_ctrl <= pwdata[3:0];
            end else if (wr && paddr == `PTF_OFF_IRQ_ENABLE) begin
                irq_enable <= pwdata[`PTF_IRQ_WIDTH-1:0];
            end
            if (limit_hit) begin
                ctrl1[`PTF_C1_RUN] <= 1'b0; // [R5]
            end
        end
    end

    // Receive counters and sticky status
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            good_cnt <= 14'h0000;
            bad_cnt <= 8'h00;
            cnt_active <= 1'b0;
            irq_status <= {`PTF_IRQ_WIDTH{1'b0}};
        end else begin
            if (rx_good) begin // [R10]
                if (rd_good) begin
                    good_cnt <= 14'h0001; // [R17]
                end else if (good_cnt == `PTF_GOOD_MAX) begin
                    good_cnt <= 14'h0000; // [R7]
                end else begin
                    good_cnt <= good_cnt + 14'd1;
                end
            end else if (rd_good) begin
                good_cnt <= 14'h0000; // [R11]
            end
            if (rx_bad) begin // [R10]
                if (rd_bad) begin
                    bad_cnt <= 8'h01; // [R17]
                end else if (bad_cnt != `PTF_BAD_MAX) begin
                    bad_cnt <= bad_cnt + 8'd1; // [R8]
                end
            end else if (rd_bad) begin
                bad_cnt <= 8'h00; // [R11]
            end
            if (med_rx_end) begin
                cnt_active <= 1'b1; // [R9]
            end else if (rd_good) begin
                cnt_active <= 1'b0; // [R9]
            end
            if (wr && paddr == `PTF_OFF_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~pwdata[`PTF_IRQ_WIDTH-1:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
        end
    end

    // Read data
    always @* begin
        prdata = 32'h0000_0000;
        if (paddr == `PTF_OFF_GEN_CTRL1) begin
            prdata = ctrl1;
        end else if (paddr == `PTF_OFF_GEN_CTRL2) begin
            prdata = ctrl2;
        end else if (paddr == `PTF_OFF_GEN_DST_LO) begin
            prdata = dst_lo;
        end else if (paddr == `PTF_OFF_GEN_SRC_LO) begin
            prdata = src_lo;
        end else if (paddr == `PTF_OFF_GEN_ADDR_HI) begin
            prdata = addr_hi;
        end else if (paddr == `PTF_OFF_GOOD_CNT) begin
            prdata = {15'h000, cnt_active, 2'b00, good_cnt};
        end else if (paddr == `PTF_OFF_BAD_CNT) begin
            prdata = {24'h000000, bad_cnt};
        end else if (paddr == `PTF_OFF_LOOP_CTRL) begin
            prdata = {28'h0000000, loop_ctrl};
        end else if (paddr == `PTF_OFF_IRQ_STATUS) begin
            prdata = {29'h0000000, irq_status};
        end else if (paddr == `PTF_OFF_IRQ_ENABLE) begin
            prdata = {29'h0000000, irq_enable};
        end
    end

    // Data path steering
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            med_tx_en <= 1'b0;
            med_txd <= 8'h00;
            med_tx_er <= 1'b0;
            mac_rx_dv <= 1'b0;
            mac_rxd <= 8'h00;
            mac_rx_er <= 1'b0;
        end else begin
            if (near_on) begin
                med_tx_en <= 1'b0; // [R14]
                med_txd <= 8'h00;
                med_tx_er <= 1'b0;
                mac_rx_dv <= mac_tx_en; // [R14]
                mac_rxd <= mac_txd;
                mac_rx_er <= mac_tx_er;
            end else begin
                if (gen_on) begin
                    med_tx_en <= gen_valid; // [R1] [R2]
                    med_txd <= gen_data;
                    med_tx_er <= gen_err;
                end else if (far_on) begin
                    med_tx_en <= med_rx_dv; // [R12] [R13]
                    med_txd <= med_rxd;
                    med_tx_er <= med_rx_er;
                end else begin
                    med_tx_en <= mac_tx_en;
                    med_txd <= mac_txd;
                    med_tx_er <= mac_tx_er;
                end
                mac_rx_dv <= med_rx_dv; // [R2] [R13]
                mac_rxd <= med_rxd;
                mac_rx_er <= med_rx_er;
            end
        end
    end
endmodule

// ===== ptf_checker_properties.sv
`timescale 1ns/1ps
`include "ptf_map.vh"
module ptf_checker (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    // MAC side
    input wire mac_tx_en,
    input wire [7:0] mac_txd,
    input wire mac_rx_dv,
    input wire [7:0] mac_rxd,
    // Media side
    input wire med_tx_en,
    input wire [7:0] med_txd,
    input wire med_rx_dv,
    input wire [7:0] med_rxd,
    input wire med_rx_end,
    input wire med_rx_crc_ok
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire acc = psel && penable && pready;
    wire rd_good = acc && !pwrite && paddr == `PTF_OFF_GOOD_CNT;
    wire rd_bad = acc && !pwrite && paddr == `PTF_OFF_BAD_CNT;
    wire good_end = med_rx_end && med_rx_crc_ok;
    reg gen_on, far_on, near_on, g_any, b_any, keep1;
    // Mode shadows and frames since last read
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {gen_on, far_on, near_on, g_any, b_any, keep1} <= 6'h00;
        end else begin
            if (acc && pwrite && paddr == `PTF_OFF_GEN_CTRL1)
                gen_on <= pwdata[0];
            if (acc && pwrite && paddr == `PTF_OFF_LOOP_CTRL)
                {near_on, far_on} <= pwdata[1:0];
            g_any <= med_rx_end || (g_any && !rd_good);
            b_any <= (med_rx_end && !med_rx_crc_ok) || (b_any && !rd_bad);
            keep1 <= (rd_good && good_end) || (keep1 && !rd_good && !med_rx_end);
        end
    end
    sequence s_near2;
        near_on [*2];
    endsequence
    sequence s_open2;
        (!near_on) [*2];
    endsequence
    sequence s_far2;
        (far_on && !near_on && !gen_on) [*2];
    endsequence
    property p_near_silent;
        s_near2 |-> !med_tx_en;
    endproperty
    property p_near_return;
        s_near2 |-> mac_rx_dv == $past(mac_tx_en) && (!mac_rx_dv || mac_rxd == $past(mac_txd));
    endproperty
    property p_rx_mirror;
        s_open2 |-> mac_rx_dv == $past(med_rx_dv) && (!mac_rx_dv || mac_rxd == $past(med_rxd));
    endproperty
    property p_far_echo;
        s_far2 |-> med_tx_en == $past(med_rx_dv) && (!med_tx_en || med_txd == $past(med_rxd));
    endproperty
    property p_good_clear;
        rd_good && !g_any |-> prdata[13:0] == 14'h0000;
    endproperty
    property p_bad_clear;
        rd_bad && !b_any |-> prdata[7:0] == 8'h00;
    endproperty
    property p_kept;
        rd_good && keep1 |-> prdata[13:0] == 14'h0001;
    endproperty
    property p_active;
        rd_good |-> prdata[16] == g_any;
    endproperty
    a_near_silent: assert property (p_near_silent)
        else $error("media transmit active in near loop");
    a_near_return: assert property (p_near_return)
        else $error("near loop did not return mac transmit");
    a_rx_mirror: assert property (p_rx_mirror)
        else $error("mac receive does not follow media receive");
    a_far_echo: assert property (p_far_echo)
        else $error("far loop did not echo media receive");
    a_good_clear: assert property (p_good_clear)
        else $error("good count not cleared by read");
    a_bad_clear: assert property (p_bad_clear)
        else $error("bad count not cleared by read");
    a_kept: assert property (p_kept)
        else $error("frame lost during read clear");
    a_active: assert property (p_active)
        else $error("active flag wrong");
endmodule

// ===== ptf_partner.sv
`timescale 1ns/1ps
module ptf_partner (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Media receive toward the device
    output reg med_rx_dv = 1'b0,
    output reg [7:0] med_rxd = 8'hA5,
    output reg med_rx_er = 1'b0,
    output reg med_rx_end = 1'b0,
    output reg med_rx_crc_ok = 1'b0,
    // Media transmit from the device
    input wire med_tx_en,
    input wire [7:0] med_txd,
    input wire med_tx_er
);
    integer n_tx = 0, cnt = 0, last_len = 0;
    reg er = 1'b0, last_er = 1'b0;
    reg [7:0] hdr [0:12];
    task set_end(input e, input ok);
        med_rx_end <= e;
        med_rx_crc_ok <= ok;
    endtask
    task frame(input integer n);
        integer j;
        for (j = 0; j < n; j = j + 1) begin
            @(posedge clk_sys);
            med_rx_dv <= 1'b1;
            med_rxd <= j[7:0] ^ 8'h5A;
        end
        @(posedge clk_sys);
        med_rx_dv <= 1'b0;
        med_rxd <= ~med_rxd;
        set_end(1'b1, 1'b1);
        @(posedge clk_sys);
        set_end(1'b0, 1'b0);
    endtask
    // Frames seen on media transmit
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt = 0;
            er = 1'b0;
        end else if (med_tx_en) begin
            if (cnt < 13)
                hdr[cnt] = med_txd;
            cnt = cnt + 1;
            er = er | med_tx_er;
        end else if (cnt != 0) begin
            n_tx = n_tx + 1;
            last_len = cnt;
            last_er = er;
            cnt = 0;
            er = 1'b0;
        end
    end
endmodule

// ===== test_phy_test_features.sv
`timescale 1ns/1ps
`include "ptf_map.vh"
module test_phy_test_features;
    localparam LIM = 3;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000;
    reg [1:0] speed = 2'h2;
    reg mac_tx_en = 1'b0, mac_tx_er = 1'b0;
    reg [7:0] mac_txd = 8'h00;
    wire [31:0] prdata;
    wire [7:0] mac_rxd, med_txd, med_rxd;
    wire pready, pslverr, mac_rx_dv, mac_rx_er, med_tx_en, med_tx_er, med_rx_dv, med_rx_er;
    wire med_rx_end, med_rx_crc_ok, cable_loop_en, xover_fix_off, irq;
    integer n_fail = 0, n_checks = 0, g = 0, b = 0, act = 0, st = 0, i, k, sp;
    reg [31:0] r = 32'h0000_8841;
    reg [31:0] q, c1;
    reg [47:0] da, sa;
    reg [10:0] sz;
    ptf_test_top #(.FRAME_LIMIT(LIM)) u_dut (.clk_sys, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .speed, .mac_tx_en, .mac_txd,
        .mac_tx_er, .mac_rx_dv, .mac_rxd, .mac_rx_er, .med_tx_en, .med_txd, .med_tx_er,
        .med_rx_dv, .med_rxd, .med_rx_er, .med_rx_end, .med_rx_crc_ok, .cable_loop_en,
        .xover_fix_off, .irq);
    ptf_partner u_partner (.clk_sys, .rst, .med_rx_dv, .med_rxd, .med_rx_er, .med_rx_end,
        .med_rx_crc_ok, .med_tx_en, .med_txd, .med_tx_er);
    initial forever #12.5 clk_sys = ~clk_sys;
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, q, exp);
    endtask
    task rd_counts;
        apb(1'b0, `PTF_OFF_GOOD_CNT, 32'h0000_0000);
        chk("good", q & 32'h0001_3FFF, (act << 16) | g);
        apb(1'b0, `PTF_OFF_BAD_CNT, 32'h0000_0000);
        chk("bad", q & 32'h0000_00FF, b);
        g = 0;
        act = 0;
        b = 0;
    endtask
    task ends(input integer n, input integer mode);
        integer j;
        reg ok;
        for (j = 0; j < n; j = j + 1) begin
            @(posedge clk_sys);
            r = lfsr(r);
            ok = (mode == 2) ? r[0] : mode[0];
            u_partner.set_end(1'b1, ok);
            if (ok)
                g = (g == 9999) ? 0 : g + 1;
            else if (b < 255)
                b = b + 1;
            act = 1;
            st = st | (ok ? 2 : 4);
        end
        @(posedge clk_sys);
        u_partner.set_end(1'b0, 1'b0);
    endtask
    task mac_frame(input integer n);
        integer j;
        for (j = 0; j < n; j = j + 1) begin
            @(posedge clk_sys);
            r = lfsr(r);
            mac_tx_en <= 1'b1;
            mac_txd <= r[7:0];
        end
        @(posedge clk_sys);
        mac_tx_en <= 1'b0;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_fail = n_fail + 1;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rdc("ctrl2", `PTF_OFF_GEN_CTRL2, `PTF_RST_CTRL2);
        rdc("unmapped", 12'h0FC, 32'h0000_0000);
        ends(9999, 1);
        rd_counts();
        ends(10001, 1);
        ends(260, 0);
        rd_counts();
        ends(300, 2);
        rd_counts();
        rd_counts();
        fork
            apb(1'b0, `PTF_OFF_GOOD_CNT, 32'h0000_0000);
            begin
                repeat (2) @(posedge clk_sys);
                u_partner.set_end(1'b1, 1'b1);
                @(posedge clk_sys);
                u_partner.set_end(1'b0, 1'b0);
            end
        join
        chk("good at read", q & 32'h0001_3FFF, 32'h0000_0000);
        g = 1;
        act = 1;
        rd_counts();
        apb(1'b1, `PTF_OFF_IRQ_ENABLE, 32'h0000_0000);
        @(negedge clk_sys);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, `PTF_OFF_IRQ_ENABLE, 32'h0000_0006);
        @(negedge clk_sys);
        chk("irq raised", irq, 1'b1);
        rdc("status", `PTF_OFF_IRQ_STATUS, st);
        apb(1'b1, `PTF_OFF_IRQ_CLEAR, 32'h0000_0006);
        @(negedge clk_sys);
        chk("irq cleared", irq, 1'b0);
        rdc("status", `PTF_OFF_IRQ_STATUS, 32'h0000_0000);
        $display("test counters done");
        for (sp = 2; sp >= 0; sp = sp - 1) begin
            speed <= sp[1:0];
            r = lfsr(r);
            da = {r[15:0], lfsr(r)};
            r = lfsr(lfsr(r));
            sa = {r[31:16], lfsr(r)};
            sz = (sp == 2) ? 11'h040 + r[3:0] : 11'h040;
            apb(1'b1, `PTF_OFF_GEN_DST_LO, da[31:0]);
            apb(1'b1, `PTF_OFF_GEN_SRC_LO, sa[31:0]);
            apb(1'b1, `PTF_OFF_GEN_ADDR_HI, {sa[47:32], da[47:32]});
            apb(1'b1, `PTF_OFF_GEN_CTRL2, {16'h000C, 5'h00, sz});
            apb(1'b1, `PTF_OFF_IRQ_ENABLE, 32'h0000_0001);
            apb(1'b1, `PTF_OFF_GEN_CTRL1, 32'h0000_0001);
            k = u_partner.n_tx;
            mac_frame(8);
            repeat (3) @(negedge clk_sys);
            chk("mac dropped", u_partner.n_tx, k);
            c1 = {20'h00000, r[23:16], sp == 2, 3'h3};
            apb(1'b1, `PTF_OFF_GEN_CTRL1, c1);
            while (irq !== 1'b1)
                @(posedge clk_sys);
            repeat (4) @(negedge clk_sys);
            chk("gen frames", u_partner.n_tx, k + LIM);
            rdc("run cleared", `PTF_OFF_GEN_CTRL1, c1 ^ 32'h0000_0002);
            if (sp == 2) begin
                for (i = 0; i < 12; i = i + 1)
                    chk("addr", u_partner.hdr[i], i < 6 ? da[47 - 8 * i -: 8] : sa[95 - 8 * i -: 8]);
                chk("pattern", u_partner.hdr[12], r[23:16]);
                chk("size", u_partner.last_len, sz);
                chk("fcs", u_partner.last_er, 1'b1);
            end
            apb(1'b1, `PTF_OFF_IRQ_CLEAR, 32'h0000_0001);
            apb(1'b1, `PTF_OFF_GEN_CTRL1, 32'h0000_0000);
        end
        $display("test generator done");
        apb(1'b1, `PTF_OFF_LOOP_CTRL, 32'h0000_0001);
        k = u_partner.n_tx;
        fork
            u_partner.frame(8);
            mac_frame(8);
        join
        g = g + 1;
        act = 1;
        repeat (3) @(negedge clk_sys);
        chk("far frames", u_partner.n_tx, k + 1);
        chk("far length", u_partner.last_len, 8);
        rd_counts();
        apb(1'b1, `PTF_OFF_LOOP_CTRL, 32'h0000_0002);
        mac_frame(8);
        repeat (3) @(negedge clk_sys);
        chk("near quiet", u_partner.n_tx, k + 1);
        apb(1'b1, `PTF_OFF_LOOP_CTRL, 32'h0000_0004);
        @(negedge clk_sys);
        chk("cable", {cable_loop_en, xover_fix_off}, 2'h2);
        apb(1'b1, `PTF_OFF_LOOP_CTRL, 32'h0000_000C);
        @(negedge clk_sys);
        chk("cable xover", {cable_loop_en, xover_fix_off}, 2'h3);
        rdc("loop", `PTF_OFF_LOOP_CTRL, 32'h0000_000C);
        $display("test loopback done");
        ends(5, 2);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        {g, b, act} = 0;
        @(negedge clk_sys);
        chk("cable after reset", cable_loop_en, 1'b0);
        rd_counts();
        $display("test reset done");
        give_verdict();
    end
endmodule
bind ptf_test_top ptf_checker u_chk (.clk_sys, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .mac_tx_en, .mac_txd, .mac_rx_dv,
    .mac_rxd, .med_tx_en, .med_txd, .med_rx_dv, .med_rxd, .med_rx_end, .med_rx_crc_ok);
